// ==== design/dcab_consts.svh ====
// constants of the chain-mode readout block with busy indicator
`ifndef DCAB_CONSTS_SVH
`define DCAB_CONSTS_SVH

// ----------------------------------------
// data layout
// ----------------------------------------
`define DCAB_RESULT_BITS 16
`define DCAB_RESULT_MSB 15

// ----------------------------------------
// timing
// ----------------------------------------
`define DCAB_CLOCK_MHZ 200
`define DCAB_CONV_TIME_NS 2200
`define DCAB_CONV_CYCLES ((`DCAB_CONV_TIME_NS * `DCAB_CLOCK_MHZ + 999) / 1000)

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCAB_STATE_RESET 3'h1

`endif

// ==== design/dcab_pkg.sv ====
// types of the chain-mode readout block
package dcab_pkg;

   // ----------------------------------------
   // conversion engine states
   // ----------------------------------------
   typedef enum logic [2:0] {
      DCAB_IDLE = 3'h1,
      DCAB_CONV = 3'h2,
      DCAB_ACQ  = 3'h4
   } dcab_state_e;

   // ----------------------------------------
   // word handed to the link side
   // ----------------------------------------
   typedef struct packed {
      logic busyEn;
      logic loadTgl;
      logic [15:0] word;
   } dcab_load_s;

endpackage

// ==== design/dcab_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module dcab_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= din;
         stage2_r <= stage1_r;
      end
   end

   assign dout = stage2_r;

endmodule

// ==== design/dcab_readout.sv ====
// chain-mode serial readout of a 16-bit converter, busy indicator capable
`timescale 1ns/1ps
`include "dcab_consts.svh"
module dcab_readout #(
   parameter int RESULT_BITS = `DCAB_RESULT_BITS,
   parameter int CONV_CYCLES = `DCAB_CONV_CYCLES
) (
   // system clock and reset
   input wire logic clock,
   input wire logic reset,
   // serial pins
   input wire logic convert_start,
   input wire logic serialClock,
   input wire logic serial_data_in,
   output logic serial_data_out,
   // converter core
   input wire logic [RESULT_BITS-1:0] sampleCode,
   output logic convPowerOn,
   output logic busyModeOn
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pinSync;
   logic cnvS;
   logic sclkS;
   logic sdiS;

   dcab_sync #(.WIDTH(3)) u_pinSync (
      .clock(clock),
      .reset(reset),
      .din({convert_start, serialClock, serial_data_in}),
      .dout(pinSync)
   );

   assign cnvS = pinSync[2];
   assign sclkS = pinSync[1];
   assign sdiS = pinSync[0];

   logic cnvLast_r;
   wire cnvRise = cnvS && !cnvLast_r;

   // ----------------------------------------
   // conversion engine
   // ----------------------------------------
   dcab_pkg::dcab_state_e state_r;
   dcab_pkg::dcab_state_e state_nxt;
   logic [15:0] convCnt_r;
   logic [15:0] convCnt_nxt;
   logic busyEn_r;
   logic [RESULT_BITS-1:0] result_r;
   logic loadTgl_r;
   logic ackS;

   wire convLast = (convCnt_r == 16'(CONV_CYCLES - 1));
   wire inConv = (state_r == dcab_pkg::DCAB_CONV);
   wire inAcq = (state_r == dcab_pkg::DCAB_ACQ);
   wire pending = (loadTgl_r != ackS);

   always_comb begin
      state_nxt = state_r;
      convCnt_nxt = convCnt_r;
      case (state_r)
         dcab_pkg::DCAB_IDLE: begin
            if (cnvRise) begin
               state_nxt = dcab_pkg::DCAB_CONV;
               convCnt_nxt = 16'h0000;
            end
         end
         dcab_pkg::DCAB_CONV: begin
            if (convLast) begin
               state_nxt = dcab_pkg::DCAB_ACQ;
            end else begin
               convCnt_nxt = convCnt_r + 16'h0001;
            end
         end
         dcab_pkg::DCAB_ACQ: begin
            // powered down until the next start rise
            if (cnvRise) begin
               state_nxt = dcab_pkg::DCAB_CONV;
               convCnt_nxt = 16'h0000;
            end
         end
         default: begin
            state_nxt = dcab_pkg::DCAB_IDLE;
            convCnt_nxt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_r <= dcab_pkg::dcab_state_e'(`DCAB_STATE_RESET);
         convCnt_r <= 16'h0000;
         cnvLast_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         convCnt_r <= convCnt_nxt;
         cnvLast_r <= cnvS;
      end
   end

   // mode chosen by the clock level at the start rise
   always_ff @(posedge clock) begin
      if (reset) begin
         busyEn_r <= 1'b0;
      end else if (cnvRise) begin
         busyEn_r <= sclkS;
      end
   end

   // result kept until shifted out
   always_ff @(posedge clock) begin
      if (reset) begin
         result_r <= '0;
         loadTgl_r <= 1'b0;
      end else if (inConv && convLast) begin
         result_r <= sampleCode;
         loadTgl_r <= !loadTgl_r;
      end
   end

   assign convPowerOn = inConv;
   assign busyModeOn = busyEn_r;

   // ----------------------------------------
   // output stage before the first falling edge
   // ----------------------------------------
   logic sdoSys_r;
   logic sdoSys_nxt;
   logic linkOwns_r;
   logic linkOwns_nxt;
   logic [RESULT_BITS-1:0] shiftReg_r;

   always_comb begin
      sdoSys_nxt = 1'b0;
      if (!cnvS && !sdiS) begin
         sdoSys_nxt = 1'b0;
      end else if (inAcq && pending) begin
         // busy flag only once upstream reports done too
         sdoSys_nxt = busyEn_r ? sdiS : result_r[RESULT_BITS-1];
      end
   end

   // a new start rise hands the pin back at once
   assign linkOwns_nxt = inAcq && cnvS && !pending && !cnvRise;

   always_ff @(posedge clock) begin
      if (reset) begin
         sdoSys_r <= 1'b0;
         linkOwns_r <= 1'b0;
      end else begin
         sdoSys_r <= sdoSys_nxt;
         linkOwns_r <= linkOwns_nxt;
      end
   end

   // both sources are flops that move only between edges
   assign serial_data_out = linkOwns_r ? shiftReg_r[RESULT_BITS-1] : sdoSys_r;

   // ----------------------------------------
   // link domain, falling edge of the serial clock
   // ----------------------------------------
   dcab_pkg::dcab_load_s load;
   logic linkClockN;
   logic linkReset;
   logic ackTgl_r;

   assign load = '{busyEn: busyEn_r, loadTgl: loadTgl_r, word: result_r};
   assign linkClockN = !serialClock;

   dcab_sync #(.WIDTH(1)) u_linkReset (
      .clock(linkClockN),
      .reset(1'b0),
      .din(reset),
      .dout(linkReset)
   );

   // load fields are static long before the host clocks after completion
   wire firstEdge = (load.loadTgl != ackTgl_r);

   always_ff @(negedge serialClock) begin
      if (linkReset) begin
         ackTgl_r <= 1'b0;
         shiftReg_r <= '0;
      end else if (firstEdge) begin
         ackTgl_r <= load.loadTgl;
         // busy bit is dropped, else the msb already shown is passed
         shiftReg_r <= load.busyEn ? load.word : {load.word[RESULT_BITS-2:0], serial_data_in};
      end else begin
         shiftReg_r <= {shiftReg_r[RESULT_BITS-2:0], serial_data_in};
      end
   end

   dcab_sync #(.WIDTH(1)) u_ackSync (
      .clock(clock),
      .reset(reset),
      .din(ackTgl_r),
      .dout(ackS)
   );

   // ----------------------------------------
   // checks, system domain
   // ----------------------------------------
   sequence convStart;
      cnvRise && !inConv;
   endsequence

   sequence convEnd;
      inConv && convLast;
   endsequence

   AST_IDLE_LOW: assert property (@(posedge clock) disable iff (reset)
      (!cnvS && !sdiS) |=> !serial_data_out)
      else $error("output not low while start and input are low");

   AST_BUSY_MODE: assert property (@(posedge clock) disable iff (reset)
      (convStart ##0 sclkS) |=> (busyEn_r && inConv))
      else $error("busy mode not chosen with clock high");

   AST_NOBUSY_MODE: assert property (@(posedge clock) disable iff (reset)
      (convStart ##0 !sclkS) |=> (!busyEn_r && inConv))
      else $error("busy mode chosen with clock low");

   AST_CONV_DONE: assert property (@(posedge clock) disable iff (reset)
      convEnd |=> (inAcq && !convPowerOn && result_r == $past(sampleCode)))
      else $error("conversion did not end into acquisition");

   AST_ACQ_HOLD: assert property (@(posedge clock) disable iff (reset)
      (inAcq && !cnvRise) |=> (inAcq && !convPowerOn))
      else $error("acquisition left without a start rise");

   AST_CONV_LEN: assert property (@(posedge clock) disable iff (reset)
      inConv |-> (convCnt_r < 16'(CONV_CYCLES)))
      else $error("conversion ran past its length");

   AST_BUSY_FLAG: assert property (@(posedge clock) disable iff (reset)
      (inAcq && pending && busyEn_r && sdiS && cnvS) |=> serial_data_out)
      else $error("busy flag not raised after completion");

   AST_BUSY_WAIT: assert property (@(posedge clock) disable iff (reset)
      ((inConv && busyEn_r) or (inAcq && pending && busyEn_r && !sdiS)) |=> !serial_data_out)
      else $error("busy flag raised too early");

   AST_MSB_FIRST: assert property (@(posedge clock) disable iff (reset)
      (inAcq && pending && !busyEn_r && cnvS) |=> (serial_data_out == result_r[RESULT_BITS-1]))
      else $error("msb not shown at completion");

   // ----------------------------------------
   // checks, link domain
   // ----------------------------------------
   AST_SHIFT_IN: assert property (@(negedge serialClock) disable iff (linkReset)
      !firstEdge |=> (shiftReg_r == {$past(shiftReg_r[RESULT_BITS-2:0]), $past(serial_data_in)}))
      else $error("serial input not shifted in");

   AST_FIRST_LOAD: assert property (@(negedge serialClock) disable iff (linkReset)
      (firstEdge && load.busyEn) |=> (shiftReg_r == $past(load.word) && !firstEdge))
      else $error("result not loaded on first edge");

endmodule

// ==== dv/dcab_host.sv ====
// host model: start rises and serial clock frames of the chain readout
`timescale 1ns/1ps
module dcab_host (
   // system clock
   input wire logic clock,
   // serial pins
   output logic convert_start,
   output logic serialClock,
   input wire logic serial_data_out
);
   logic [15:0] wordSeen;
   event wordDone;
   int rdMiss;
   initial begin
      convert_start = 1'b0;
      serialClock = 1'b0;
      rdMiss = 0;
   end
   // ----------------------------------------
   // frames
   // ----------------------------------------
   // free pulses so the link side leaves reset
   task automatic pulses(input int n);
      repeat (n) begin
         #62.5 serialClock = 1'b1;
         #62.5 serialClock = 1'b0;
      end
   endtask
   // clock level at the start rise picks the mode
   task automatic start(input logic busy);
      @(negedge clock);
      serialClock = busy;
      @(negedge clock);
      convert_start = 1'b1;
   endtask
   // capture just before each fall, the first skip falls dropped
   task automatic readback(input int falls, input int skip);
      logic onRise;
      int got;
      got = 0;
      #1.3;
      for (int k = 1; k <= falls; k++) begin
         if (serialClock === 1'b0) begin
            #62.5 serialClock = 1'b1;
         end
         onRise = serial_data_out;
         #62.5;
         if (onRise !== serial_data_out) rdMiss++;
         if (k > skip) begin
            wordSeen = {wordSeen[14:0], serial_data_out};
            got++;
            if (got % 16 == 0) -> wordDone;
         end
         serialClock = 1'b0;
      end
      #62.5;
   endtask
   // start stays high until the frame is over
   task automatic stop();
      @(negedge clock);
      convert_start = 1'b0;
   endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench of the chain-mode readout
`timescale 1ns/1ps
module tb_top;
   localparam int CONV = 8;
   logic clock, reset, serial_data_in, serial_data_out, convPowerOn, busyModeOn, convert_start, serialClock;
   logic [15:0] sampleCode;
   logic [16:0] upWord;
   logic [15:0] expQ[$];
   int errors, checks, seed, onCount;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   dcab_readout #(.RESULT_BITS(16), .CONV_CYCLES(CONV)) u_dcab_readout (.clock(clock), .reset(reset),
      .convert_start(convert_start), .serialClock(serialClock), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .sampleCode(sampleCode), .convPowerOn(convPowerOn),
      .busyModeOn(busyModeOn));
   dcab_host u_dcab_host (.clock(clock), .convert_start(convert_start), .serialClock(serialClock),
      .serial_data_out(serial_data_out));
   always #2.5 clock = ~clock;
   // upstream device: in busy mode a busy flag, then its word msb first
   always @(negedge serialClock) upWord <= {upWord[15:0], 1'b0};
   assign serial_data_in = upWord[16];
   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic cmpVal(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   always @(u_dcab_host.wordDone) begin
      if (expQ.size() == 0) cmpVal("spare word", 32'h0, u_dcab_host.wordSeen);
      else cmpVal("read word", expQ.pop_front(), u_dcab_host.wordSeen);
   end
   task automatic close_out();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // one conversion and readback, N = 2
   // ----------------------------------------
   task automatic frame(input logic busy);
      logic [15:0] own, up;
      int waitCnt;
      own = $random(seed);
      up = $random(seed);
      @(negedge clock);
      sampleCode = own;
      upWord = busy ? {1'b0, up} : {up, 1'b0};
      u_dcab_host.start(busy);
      waitCnt = 0;
      while (convPowerOn !== 1'b1 && waitCnt < 20) begin
         @(negedge clock);
         waitCnt++;
      end
      cmpVal("mode flag", busy, busyModeOn);
      onCount = 0;
      while (convPowerOn === 1'b1 && onCount < 1000) begin
         cmpVal("output in conversion", 1'b0, serial_data_out);
         @(negedge clock);
         onCount++;
      end
      cmpVal("conversion length", CONV, onCount);
      repeat (10) @(negedge clock);
      if (busy) begin
         cmpVal("flag with upstream busy", 1'b0, serial_data_out);
         upWord[16] = 1'b1;
         repeat (10) @(negedge clock);
         cmpVal("busy flag", 1'b1, serial_data_out);
      end
      expQ.push_back(own);
      expQ.push_back(up);
      u_dcab_host.readback(busy ? 33 : 32, busy ? 1 : 0);
      cmpVal("power after completion", 1'b0, convPowerOn);
      u_dcab_host.stop();
      repeat (5) @(negedge clock);
      cmpVal("output released", 1'b0, serial_data_out);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      sampleCode = 16'h0000;
      upWord = 17'h00000;
      seed = 30839;
      errors = 0;
      checks = 0;
      u_dcab_host.pulses(4);
      @(negedge clock);
      reset = 1'b0;
      // link reset only lets go after further serial clock falls
      u_dcab_host.pulses(3);
      repeat (5) @(negedge clock);
      cmpVal("idle output", 1'b0, serial_data_out);
      cmpVal("idle power", 1'b0, convPowerOn);
      for (int i = 0; i < 4; i++) frame(i[0]);
      cmpVal("edge agreement", 0, u_dcab_host.rdMiss);
      cmpVal("words left", 0, expQ.size());
      close_out();
   end
   initial begin
      #100000;
      errors++;
      close_out();
   end
endmodule
